// ### inc/sbst_map.vh
`ifndef SBST_MAP_VH
`define SBST_MAP_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SBST_IR_W 3
`define SBST_ID_W 32
`define SBST_BSR_W 16

// ----------------------------------------------------------------
// instruction codes, msb on the left
// ----------------------------------------------------------------
`define SBST_OP_EXTEST 3'h0
`define SBST_OP_IDCODE 3'h1
`define SBST_OP_SAMPZ 3'h2
`define SBST_OP_PRIV0 3'h3
`define SBST_OP_SAMPLE 3'h4
`define SBST_OP_PRIV1 3'h5
`define SBST_OP_PRIV2 3'h6
`define SBST_OP_BYPASS 3'h7

// ----------------------------------------------------------------
// capture values and pinless cells
// ----------------------------------------------------------------
`define SBST_IR_CAPTURE 3'h1
`define SBST_BYP_CAPTURE 1'h0
`define SBST_PINLESS_MASK 16'hc000
`define SBST_PINLESS_DFLT 16'hffff

`endif

// ### core/sbst_buf2.v
`timescale 1ns/100ps
`default_nettype none

module sbst_buf2 #(
   parameter W = 16
) (
   input wire mclk,
   input wire rst_n,
   input wire inValid,
   output wire inReady,
   input wire [W-1:0] inData,
   output wire outValid,
   input wire outReady,
   output reg [W-1:0] outData
);

   // ----------------------------------------------------------------
   // two entries: head register drives the port, tail holds the spare
   // ----------------------------------------------------------------
   reg [W-1:0] tail;
   reg [1:0] count;
   wire push;
   wire pop;

   assign inReady = (count != 2'h2);
   assign outValid = (count != 2'h0);
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         outData <= {W{1'b0}};
         tail <= {W{1'b0}};
         count <= 2'h0;
      end else begin
         if (pop) begin
            if (count == 2'h2) begin
               outData <= tail;
            end else if (push) begin
               outData <= inData;
            end
         end else if (push && count == 2'h0) begin
            outData <= inData;
         end
         if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop))) begin
            tail <= inData;
         end
         if (push && !pop) begin
            count <= count + 2'h1;
         end else if (pop && !push) begin
            count <= count - 2'h1;
         end
      end
   end

endmodule // sbst_buf2

`default_nettype wire

// ### core/sbst_tap.v
`timescale 1ns/100ps
`default_nettype none
`include "sbst_map.vh"

module sbst_tap #(
   // arbitrary neutral value, bit 0 set as the identity format expects
   parameter [`SBST_ID_W-1:0] ID_CODE = 32'h0a5a5001
) (
   input wire mclk,
   input wire rst_n,
   input wire tck,
   input wire tms,
   input wire tdi,
   output reg tdo,
   output reg tdoOe,
   input wire [`SBST_BSR_W-1:0] pinLevel,
   output wire [`SBST_BSR_W-1:0] bsrOut,
   output wire bsrOutValid,
   input wire bsrOutReady,
   output reg outFloat,
   output reg outDrive
);

   // ----------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------
   localparam [3:0] ST_TLR = 4'h0;
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_SELDR = 4'h2;
   localparam [3:0] ST_CAPDR = 4'h3;
   localparam [3:0] ST_SHDR = 4'h4;
   localparam [3:0] ST_EX1DR = 4'h5;
   localparam [3:0] ST_PSDR = 4'h6;
   localparam [3:0] ST_EX2DR = 4'h7;
   localparam [3:0] ST_UPDR = 4'h8;
   localparam [3:0] ST_SELIR = 4'h9;
   localparam [3:0] ST_CAPIR = 4'ha;
   localparam [3:0] ST_SHIR = 4'hb;
   localparam [3:0] ST_EX1IR = 4'hc;
   localparam [3:0] ST_PSIR = 4'hd;
   localparam [3:0] ST_EX2IR = 4'he;
   localparam [3:0] ST_UPIR = 4'hf;

   // ----------------------------------------------------------------
   // pin synchronisers and tck edge finding
   // ----------------------------------------------------------------
   reg tckMeta, tckSync, tckPrev;
   reg tmsMeta, tmsSync;
   reg tdiMeta, tdiSync;
   reg [`SBST_BSR_W-1:0] pinMeta, pinSync;
   wire tckRise;
   wire tckFall;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tckMeta <= 1'b0;
         tckSync <= 1'b0;
         tckPrev <= 1'b0;
         tmsMeta <= 1'b1;
         tmsSync <= 1'b1;
         tdiMeta <= 1'b1;
         tdiSync <= 1'b1;
         pinMeta <= {`SBST_BSR_W{1'b0}};
         pinSync <= {`SBST_BSR_W{1'b0}};
      end else begin
         tckMeta <= tck;
         tckSync <= tckMeta;
         tckPrev <= tckSync;
         tmsMeta <= tms;
         tmsSync <= tmsMeta;
         tdiMeta <= tdi;
         tdiSync <= tdiMeta;
         // pins are only observed here; the pinless mask gates them later on their way to the array
         pinMeta <= pinLevel;
         pinSync <= pinMeta;
      end
   end

   assign tckRise = tckSync && !tckPrev;
   assign tckFall = !tckSync && tckPrev;

   // ----------------------------------------------------------------
   // controller state machine
   // ----------------------------------------------------------------
   reg [3:0] state;
   reg [3:0] next_state;

   always @* begin
      case (state)
         ST_TLR: next_state = tmsSync ? ST_TLR : ST_IDLE;
         ST_IDLE: next_state = tmsSync ? ST_SELDR : ST_IDLE;
         ST_SELDR: next_state = tmsSync ? ST_SELIR : ST_CAPDR;
         ST_CAPDR: next_state = tmsSync ? ST_EX1DR : ST_SHDR;
         ST_SHDR: next_state = tmsSync ? ST_EX1DR : ST_SHDR;
         ST_EX1DR: next_state = tmsSync ? ST_UPDR : ST_PSDR;
         ST_PSDR: next_state = tmsSync ? ST_EX2DR : ST_PSDR;
         ST_EX2DR: next_state = tmsSync ? ST_UPDR : ST_SHDR;
         ST_UPDR: next_state = tmsSync ? ST_SELDR : ST_IDLE;
         ST_SELIR: next_state = tmsSync ? ST_TLR : ST_CAPIR;
         ST_CAPIR: next_state = tmsSync ? ST_EX1IR : ST_SHIR;
         ST_SHIR: next_state = tmsSync ? ST_EX1IR : ST_SHIR;
         ST_EX1IR: next_state = tmsSync ? ST_UPIR : ST_PSIR;
         ST_PSIR: next_state = tmsSync ? ST_EX2IR : ST_PSIR;
         ST_EX2IR: next_state = tmsSync ? ST_UPIR : ST_SHIR;
         ST_UPIR: next_state = tmsSync ? ST_SELDR : ST_IDLE;
         default: next_state = ST_TLR;
      endcase
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_TLR;
      end else if (tckRise) begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // instruction, bypass, identity and boundary registers
   // ----------------------------------------------------------------
   reg [`SBST_IR_W-1:0] irShift;
   reg [`SBST_IR_W-1:0] irActive;
   reg bypassBit;
   reg [`SBST_ID_W-1:0] idShift;
   reg [`SBST_BSR_W-1:0] bsr;
   wire selBsr;
   wire selId;
   wire [`SBST_BSR_W-1:0] captureWord;

   // private codes fall back to bypass so the chain stays one bit long
   assign selBsr = (irActive == `SBST_OP_EXTEST) || (irActive == `SBST_OP_SAMPLE)
      || (irActive == `SBST_OP_SAMPZ);
   assign selId = (irActive == `SBST_OP_IDCODE);
   assign captureWord = (pinSync & ~`SBST_PINLESS_MASK)
      | (`SBST_PINLESS_DFLT & `SBST_PINLESS_MASK);

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irShift <= `SBST_IR_CAPTURE;
         bypassBit <= `SBST_BYP_CAPTURE;
         idShift <= {`SBST_ID_W{1'b0}};
         bsr <= {`SBST_BSR_W{1'b0}};
      end else if (tckRise) begin
         case (state)
            ST_CAPIR: irShift <= `SBST_IR_CAPTURE;
            ST_SHIR: irShift <= {tdiSync, irShift[`SBST_IR_W-1:1]};
            ST_CAPDR: begin
               if (selBsr) begin
                  bsr <= captureWord;
               end else if (selId) begin
                  idShift <= ID_CODE;
               end else begin
                  bypassBit <= `SBST_BYP_CAPTURE;
               end
            end
            ST_SHDR: begin
               if (selBsr) begin
                  bsr <= {tdiSync, bsr[`SBST_BSR_W-1:1]};
               end else if (selId) begin
                  idShift <= {tdiSync, idShift[`SBST_ID_W-1:1]};
               end else begin
                  bypassBit <= tdiSync;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // falling tck: instruction update, tdo, output drive
   // ----------------------------------------------------------------
   reg pushPending;
   wire bufInReady;
   wire updateWord;

   // extest latches the ring onto the drivers at update-ir and update-dr
   assign updateWord = tckFall && (((state == ST_UPIR) && (irShift == `SBST_OP_EXTEST))
      || ((state == ST_UPDR) && (irActive == `SBST_OP_EXTEST)));

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irActive <= `SBST_OP_IDCODE;
         tdo <= 1'b0;
         tdoOe <= 1'b0;
         outFloat <= 1'b0;
         outDrive <= 1'b0;
      end else begin
         if (state == ST_TLR) begin
            irActive <= `SBST_OP_IDCODE;
            outFloat <= 1'b0;
            outDrive <= 1'b0;
         end else if (tckFall && state == ST_UPIR) begin
            irActive <= irShift;
            outFloat <= (irShift == `SBST_OP_SAMPZ);
            outDrive <= (irShift == `SBST_OP_EXTEST);
         end
         if (tckFall) begin
            tdoOe <= (state == ST_SHIR) || (state == ST_SHDR);
            if (state == ST_SHIR) begin
               tdo <= irShift[0];
            end else if (state == ST_SHDR) begin
               if (selBsr) begin
                  tdo <= bsr[0];
               end else if (selId) begin
                  tdo <= idShift[0];
               end else begin
                  tdo <= bypassBit;
               end
            end else begin
               tdo <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // drive words toward the output drivers
   // ----------------------------------------------------------------
   // a full buffer holds one word pending; a second update while still
   // pending replaces it, since only the latest ring value matters
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pushPending <= 1'b0;
      end else if (updateWord) begin
         pushPending <= 1'b1;
      end else if (bufInReady) begin
         pushPending <= 1'b0;
      end
   end

   sbst_buf2 #(
      .W(`SBST_BSR_W)
   ) u_buf (
      .mclk(mclk),
      .rst_n(rst_n),
      .inValid(pushPending),
      .inReady(bufInReady),
      .inData(bsr),
      .outValid(bsrOutValid),
      .outReady(bsrOutReady),
      .outData(bsrOut)
   );

endmodule // sbst_tap

`default_nettype wire

// ### tb/sbst_tap_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbst_map.vh"

module sbst_tap_assertions (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tdo,
   input wire logic tdoOe,
   input wire logic [`SBST_BSR_W-1:0] bsrOut,
   input wire logic bsrOutValid,
   input wire logic bsrOutReady,
   input wire logic outFloat,
   input wire logic outDrive
);
   default clocking cb @(posedge mclk); endclocking
   // ----
   // tdo, tdoOe and the set edges of outFloat/outDrive move only in the low half of tck
   // ----
   a_reset_quiet: assert property (!rst_n |->
      !tdo && !tdoOe && !outFloat && !outDrive && !bsrOutValid)
      else $error("outputs active in reset");
   a_tdo_idle: assert property (disable iff (!rst_n) !tdoOe |-> !tdo)
      else $error("tdo set while undriven");
   a_mode_excl: assert property (disable iff (!rst_n) !(outFloat && outDrive))
      else $error("float and drive both set");
   a_oe_on_fall: assert property (disable iff (!rst_n)
      $changed(tdoOe) |-> !tck && !$past(tck))
      else $error("tdo enable moved outside tck low");
   a_tdo_on_fall: assert property (disable iff (!rst_n)
      $changed(tdo) |-> !tck && !$past(tck))
      else $error("tdo moved outside tck low");
   // leaving via test-logic-reset happens on a rise, so only the set edge is tied
   a_float_on_fall: assert property (disable iff (!rst_n)
      $rose(outFloat) |-> !tck && !$past(tck))
      else $error("float set outside update fall");
   a_drive_on_fall: assert property (disable iff (!rst_n)
      $rose(outDrive) |-> !tck && !$past(tck))
      else $error("drive set outside update fall");
   a_word_held: assert property (disable iff (!rst_n)
      bsrOutValid && !bsrOutReady |=> bsrOutValid && $stable(bsrOut))
      else $error("stalled word lost");
endmodule // sbst_tap_assertions

bind sbst_tap sbst_tap_assertions chk (.mclk, .rst_n, .tck, .tdo, .tdoOe, .bsrOut,
   .bsrOutValid, .bsrOutReady, .outFloat, .outDrive);
`default_nettype wire

// ### tb/sbst_ctl.sv
`timescale 1ns/100ps
`default_nettype none

module sbst_ctl (
   input wire logic mclk,
   input wire logic tdo,
   input wire logic tdoOe,
   output logic tck,
   output logic tms,
   output logic tdi
);
   // tck parked low outside frames, tms/tdi at pull-up level
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   task automatic half();
      repeat (4) @(posedge mclk);
      #1;
   endtask
   // ----
   // tms/tdi move with the fall, tdo read just before the rise
   // ----
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      half();
      q = tdoOe ? tdo : 1'bz;
      tck = 1'b1;
      half();
      tck = 1'b0;
   endtask
   task automatic reset5();
      logic q;
      repeat (5) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask
   task automatic shift(input logic ir, input int n, input logic [31:0] din,
      output logic [31:0] dout);
      logic q;
      dout = 32'h0;
      step(1'b0, 1'b1, q);
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask
endmodule // sbst_ctl
`default_nettype wire

// ### tb/sbst_tap_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbst_map.vh"

module sbst_tap_tb_top;
   // arbitrary identity value
   localparam logic [31:0] ID = 32'h13579bdf;
   localparam logic [15:0] PINS = 16'h2a5c;
   localparam logic [15:0] CAP = (PINS & ~`SBST_PINLESS_MASK)
      | (`SBST_PINLESS_DFLT & `SBST_PINLESS_MASK);
   localparam logic [15:0] PINS2 = 16'h5a3c;
   localparam logic [15:0] CAP2 = (PINS2 & ~`SBST_PINLESS_MASK)
      | (`SBST_PINLESS_DFLT & `SBST_PINLESS_MASK);
   typedef struct packed {
      logic [2:0] op;
      int n;
      logic [31:0] din;
      logic [31:0] dout;
      logic [1:0] mode;
   } sbst_row_t;
   logic mclk, rst_n, tck, tms, tdi, tdo, tdoOe, bsrOutValid, bsrOutReady, outFloat, outDrive;
   logic [15:0] pinLevel;
   logic [15:0] bsrOut;
   logic [31:0] got;
   int n_fail = 0;
   int checks = 0;
   // bypass shows its captured 0 first, then tdi one tck late
   sbst_row_t rows [5] = '{
      '{`SBST_OP_IDCODE, 32, 32'h0, ID, 2'h0},
      '{`SBST_OP_BYPASS, 8, 32'ha5, 32'h4a, 2'h0},
      '{`SBST_OP_SAMPZ, 16, 32'h0f0f, CAP, 2'h2},
      '{`SBST_OP_SAMPLE, 16, 32'h1234, CAP, 2'h0},
      '{`SBST_OP_EXTEST, 16, 32'hbeef, CAP, 2'h1}};

   sbst_tap #(.ID_CODE(ID)) uut (.mclk, .rst_n, .tck, .tms, .tdi, .tdo, .tdoOe, .pinLevel,
      .bsrOut, .bsrOutValid, .bsrOutReady, .outFloat, .outDrive);
   sbst_ctl ctl (.mclk, .tdo, .tdoOe, .tck, .tms, .tdi);

   always #50 mclk = ~mclk;

   // ----
   // checking and closing
   // ----
   task automatic stop_test();
      if (n_fail == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic pop(input logic [15:0] e);
      int t;
      for (t = 0; t < 20 && bsrOutValid !== 1'b1; t++) @(posedge mclk);
      if (t == 20) begin
         n_fail++;
         stop_test();
      end
      #1;
      cmp(bsrOut, e);
      bsrOutReady = 1'b1;
      @(posedge mclk);
      #1;
      bsrOutReady = 1'b0;
   endtask

   initial begin
      mclk = 1'b0;
      // a real falling edge at 1 ns, so the async reset acts before any clock
      rst_n = 1'b1;
      #1;
      rst_n = 1'b0;
      pinLevel = PINS;
      bsrOutReady = 1'b0;
      repeat (20) @(posedge mclk);
      #1;
      cmp({tdo, tdoOe, outFloat, outDrive, bsrOutValid}, 32'h0);
      rst_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      ctl.shift(1'b0, 32, 32'h0, got);
      cmp(got, ID);
      for (int k = 0; k < 5; k++) begin
         ctl.shift(1'b1, 3, {29'h0, rows[k].op}, got);
         cmp(got, `SBST_IR_CAPTURE);
         cmp({outFloat, outDrive}, rows[k].mode);
         ctl.shift(1'b0, rows[k].n, rows[k].din, got);
         cmp(got, rows[k].dout);
      end
      // receiver stalled: two words buffered, a third pending
      ctl.shift(1'b0, 16, 32'h5a5a, got);
      cmp(got, CAP);
      pop(16'h1234);
      pop(16'hbeef);
      pop(16'h5a5a);
      repeat (3) @(posedge mclk);
      cmp(bsrOutValid, 1'b0);
      ctl.reset5();
      cmp(outDrive, 1'b0);
      ctl.shift(1'b0, 32, 32'h0, got);
      cmp(got, ID);
      ctl.shift(1'b1, 3, 32'h0, got);
      cmp(outDrive, 1'b1);
      rst_n = 1'b0;
      @(posedge mclk);
      #1;
      cmp({outDrive, bsrOutValid, tdoOe}, 32'h0);
      rst_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      ctl.shift(1'b0, 32, 32'h0, got);
      cmp(got, ID);
      // a new pin ring must reach the register, pinless cells still forced
      pinLevel = PINS2;
      ctl.shift(1'b1, 3, {29'h0, `SBST_OP_SAMPLE}, got);
      cmp(got, `SBST_IR_CAPTURE);
      ctl.shift(1'b0, 16, 32'h0, got);
      cmp(got, CAP2);
      stop_test();
   end
endmodule // sbst_tap_tb_top
`default_nettype wire
